//--- rtl/block_memory_pkg.sv
// ------------------------------------------------------------
// Overview of operation
// - address and write data of each port are registered before the array.
// - each port output is either straight from the output latch or re-registered.
// - normal mode drives array data only on reads, never on writes.
// - write-through mode drives the written data onto the same port.
// - read-before-write drives the old word; only for 9, 18, 36-bit widths.
// - both output latches reset, asynchronous or synchronous style selectable.
// - one local reset per port clears only that port's output latch and pipeline register.
// - active-low global reset clears both output latches together.
// - the block holds 18 kilobits, arranged as depth times width.
// ------------------------------------------------------------
package block_memory_pkg;

  // ------------------------------------------------------------
  // sizes and modes
  // ------------------------------------------------------------
  localparam int TOTAL_BITS    = 18432;  // 18 kbit array
  localparam int DEFAULT_WIDTH = 18;
  localparam int DEFAULT_DEPTH = TOTAL_BITS / DEFAULT_WIDTH;

  typedef enum logic [1:0] {
    WRITE_NORMAL  = 2'h0,
    WRITE_THROUGH = 2'h1,
    READ_BEFORE   = 2'h2
  } write_mode_type;

  localparam logic [1:0] RESET_VALUE_BITS = 2'h0;

endpackage : block_memory_pkg

//--- rtl/embedded_block_memory.sv
`timescale 1ns/1ns
// true dual-port 18 kbit block memory with per-port output latches
module embedded_block_memory #(
  parameter int WIDTH_A = block_memory_pkg::DEFAULT_WIDTH,
  parameter int WIDTH_B = block_memory_pkg::DEFAULT_WIDTH,
  parameter block_memory_pkg::write_mode_type MODE_A = block_memory_pkg::WRITE_NORMAL,
  parameter block_memory_pkg::write_mode_type MODE_B = block_memory_pkg::WRITE_NORMAL,
  parameter bit OUTREG_A  = 1'b0,
  parameter bit OUTREG_B  = 1'b0,
  parameter bit ASYNC_RST = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  input  wire logic                 global_set_reset_n,
  input  wire logic                 port_a_output_latch_reset,
  input  wire logic                 port_b_output_latch_reset,
  input  wire logic                 en_a,
  input  wire logic                 we_a,
  input  wire logic [10:0]          addr_a,
  input  wire logic [WIDTH_A-1:0]   din_a,
  output logic      [WIDTH_A-1:0]   dout_a,
  input  wire logic                 en_b,
  input  wire logic                 we_b,
  input  wire logic [10:0]          addr_b,
  input  wire logic [WIDTH_B-1:0]   din_b,
  output logic      [WIDTH_B-1:0]   dout_b
);

  localparam int WIDTH = WIDTH_A;  // both ports share one geometry
  localparam int DEPTH = block_memory_pkg::TOTAL_BITS / WIDTH;
  localparam int AW    = $clog2(DEPTH);

  // read-before-write exists only for 9, 18, 36-bit words
  localparam bit RBW_OK = (WIDTH == 9) || (WIDTH == 18) || (WIDTH == 36);
  localparam block_memory_pkg::write_mode_type EFF_A =
    (MODE_A == block_memory_pkg::READ_BEFORE && !RBW_OK) ? block_memory_pkg::WRITE_NORMAL
                                                         : MODE_A;
  localparam block_memory_pkg::write_mode_type EFF_B =
    (MODE_B == block_memory_pkg::READ_BEFORE && !RBW_OK) ? block_memory_pkg::WRITE_NORMAL
                                                         : MODE_B;

  // ------------------------------------------------------------
  // request qualification per port
  // ------------------------------------------------------------
  logic write_a;
  logic write_b;
  logic clear_req_a;
  logic clear_req_b;

  // a write strobe without its enable is ignored, so a parked strobe is harmless
  always_comb begin
    write_a = we_a & en_a;
    write_b = we_b & en_b;
  end

  // each local clear reaches only its own port; the global one hits both
  always_comb begin
    clear_req_a = port_a_output_latch_reset | ~global_set_reset_n;
    clear_req_b = port_b_output_latch_reset | ~global_set_reset_n;
  end

  memory_port_if #(.WIDTH(WIDTH), .ADDR_BITS(AW)) pa ();
  memory_port_if #(.WIDTH(WIDTH), .ADDR_BITS(AW)) pb ();

  typedef struct packed {
    logic [1:0]   en;
    logic [1:0]   we;
    logic [AW-1:0] addr_a;
    logic [AW-1:0] addr_b;
    logic [WIDTH-1:0] din_a;
    logic [WIDTH-1:0] din_b;
    logic [1:0]   rst_sync;
  } input_state_type;

  input_state_type state;
  input_state_type next_state;
  logic [WIDTH-1:0] array [DEPTH];

  // ------------------------------------------------------------
  // input registers
  // ------------------------------------------------------------
  always_comb begin
    next_state        = state;
    next_state.en     = {en_b, en_a};
    next_state.we     = {write_b, write_a};
    next_state.addr_a = addr_a[AW-1:0];
    next_state.addr_b = addr_b[AW-1:0];
    next_state.din_a  = din_a[WIDTH-1:0];
    next_state.din_b  = din_b[WIDTH-1:0];
    // clear requests take one register stage in the synchronous style
    next_state.rst_sync = {clear_req_b, clear_req_a};
  end

  // ------------------------------------------------------------
  // input register stage, cleared by the block reset only
  // ------------------------------------------------------------

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // array, read first so read-before-write sees the old word
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (state.we[0]) begin
      array[state.addr_a] <= state.din_a;
    end
    if (state.we[1]) begin
      array[state.addr_b] <= state.din_b;  // port b wins on a collision
    end
  end

  // ------------------------------------------------------------
  // port views handed to the output stages
  // ------------------------------------------------------------
  // combinational read of the registered address; the latch takes it next edge
  assign pa.enable     = state.en[0];
  assign pa.write      = state.we[0];
  assign pa.address    = state.addr_a;
  assign pa.write_data = state.din_a;
  assign pa.array_data = array[state.addr_a];
  assign pb.enable     = state.en[1];
  assign pb.write      = state.we[1];
  assign pb.address    = state.addr_b;
  assign pb.write_data = state.din_b;
  assign pb.array_data = array[state.addr_b];

  // reset style selection: async uses the raw combined level
  assign pa.clear       = ASYNC_RST ? 1'b0 : state.rst_sync[0];
  assign pb.clear       = ASYNC_RST ? 1'b0 : state.rst_sync[1];
  // async style acts at once but trusts the clear inputs to be glitch free
  assign pa.clear_async = ASYNC_RST & clear_req_a;
  assign pb.clear_async = ASYNC_RST & clear_req_b;

  // ------------------------------------------------------------
  // output latches and optional pipeline registers
  // ------------------------------------------------------------
  logic [WIDTH-1:0] out_a;
  logic [WIDTH-1:0] out_b;

  port_output_stage #(.MODE(EFF_A), .OUTPUT_REG(OUTREG_A), .WIDTH(WIDTH)) stage_a (
    .clk      (clk),
    .bus      (pa.latch),
    .data_out (out_a)
  );
  port_output_stage #(.MODE(EFF_B), .OUTPUT_REG(OUTREG_B), .WIDTH(WIDTH)) stage_b (
    .clk      (clk),
    .bus      (pb.latch),
    .data_out (out_b)
  );

  // ------------------------------------------------------------
  // output ports, straight from the stage registers
  // ------------------------------------------------------------
  assign dout_a = out_a[WIDTH_A-1:0];
  assign dout_b = out_b[WIDTH_B-1:0];

endmodule : embedded_block_memory

//--- rtl/memory_port_if.sv
`timescale 1ns/1ns
// signals of one array port after the input registers
interface memory_port_if #(parameter int WIDTH = 18, parameter int ADDR_BITS = 10);
  logic                 enable;
  logic                 write;
  logic [ADDR_BITS-1:0] address;
  logic [WIDTH-1:0]     write_data;
  logic [WIDTH-1:0]     array_data;   // word read from array
  logic [WIDTH-1:0]     result;       // output stage value, latch or pipeline register
  logic                 clear;        // synchronous clear of latch
  logic                 clear_async;  // asynchronous clear of latch

  modport core (input enable, write, address, write_data, output array_data);
  modport port (output enable, write, address, write_data, clear, clear_async,
                input array_data, result);
  modport latch (input enable, write, write_data, array_data, clear, clear_async,
                 output result);
endinterface : memory_port_if

//--- rtl/port_output_stage.sv
`timescale 1ns/1ns
// output latch and optional pipeline register of one port
module port_output_stage #(
  parameter block_memory_pkg::write_mode_type MODE = block_memory_pkg::WRITE_NORMAL,
  parameter bit OUTPUT_REG = 1'b0,
  parameter int WIDTH      = 18
) (
  input  wire logic   clk,
  memory_port_if.latch bus,
  output logic [WIDTH-1:0] data_out
);

  typedef struct packed {
    logic [WIDTH-1:0] latch;
    logic [WIDTH-1:0] pipe;
  } stage_state_type;

  stage_state_type state;
  stage_state_type next_state;

  // ------------------------------------------------------------
  // latch update by write mode
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    if (bus.enable) begin
      case (MODE)
        block_memory_pkg::WRITE_THROUGH: begin
          next_state.latch = bus.write ? bus.write_data : bus.array_data;
        end
        block_memory_pkg::READ_BEFORE: begin
          next_state.latch = bus.array_data;  // old word also on writes
        end
        default: begin
          if (!bus.write) begin
            next_state.latch = bus.array_data;  // hold on writes
          end
        end
      endcase
    end
    next_state.pipe = state.latch;
    if (bus.clear) begin
      next_state = '0;  // synchronous clear style
    end
  end

  // async clear is a constant load, as the reset style demands
  always_ff @(posedge clk or posedge bus.clear_async) begin
    if (bus.clear_async) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign data_out  = OUTPUT_REG ? state.pipe : state.latch;
  assign bus.result = data_out;

endmodule : port_output_stage

//--- test/embedded_block_memory_assertions.sv
`timescale 1ns/1ns
// port checker, written for port a write-through and port b read-before-write
module embedded_block_memory_checker #(
  parameter int WIDTH_A = 18,
  parameter int WIDTH_B = 18,
  parameter block_memory_pkg::write_mode_type MODE_A = block_memory_pkg::WRITE_NORMAL,
  parameter block_memory_pkg::write_mode_type MODE_B = block_memory_pkg::WRITE_NORMAL,
  parameter bit OUTREG_A = 1'b0,
  parameter bit OUTREG_B = 1'b0
) (
  input wire logic               clk,
  input wire logic               rst_n,
  input wire logic               global_set_reset_n,
  input wire logic               port_a_output_latch_reset,
  input wire logic               port_b_output_latch_reset,
  input wire logic               en_a,
  input wire logic               we_a,
  input wire logic [10:0]        addr_a,
  input wire logic [WIDTH_A-1:0] din_a,
  input wire logic [WIDTH_A-1:0] dout_a,
  input wire logic               en_b,
  input wire logic               we_b,
  input wire logic [10:0]        addr_b,
  input wire logic [WIDTH_B-1:0] din_b,
  input wire logic [WIDTH_B-1:0] dout_b
);
  logic [2:0] ca;
  logic [2:0] cb;
  // clears seen lately; a synchronous clear lands a few edges after its request
  always_ff @(posedge clk) begin
    ca <= {ca[1:0], port_a_output_latch_reset | ~global_set_reset_n};
    cb <= {cb[1:0], port_b_output_latch_reset | ~global_set_reset_n};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // the latency checks below hold for a port without its output register
  AST_WT_A: assert property (MODE_A == block_memory_pkg::WRITE_THROUGH && !OUTREG_A
    && en_a && we_a |-> ##2 dout_a == $past(din_a, 2))
    else $error("port a write-through data wrong");
  AST_RD_A: assert property (!OUTREG_A && en_a && we_a ##1 en_a && we_a ##1 en_a && !we_a
    && addr_a == $past(addr_a, 2) |-> ##2 dout_a == $past(din_a, 4))
    else $error("port a read-back wrong");
  AST_RBW_B: assert property (MODE_B == block_memory_pkg::READ_BEFORE && !OUTREG_B
    && en_b && we_b ##1 en_b && we_b
    && addr_b == $past(addr_b) |-> ##2 dout_b == $past(din_b, 3))
    else $error("port b old word wrong");
  AST_HOLD_A: assert property (!OUTREG_A && $changed(dout_a) |-> $past(en_a, 2) || |ca)
    else $error("port a output moved without cause");
  AST_HOLD_B: assert property (!OUTREG_B && $changed(dout_b) |-> $past(en_b, 2) || |cb)
    else $error("port b output moved without cause");
  AST_CLR_A: assert property (port_a_output_latch_reset [*4] |-> dout_a == '0)
    else $error("port a latch not cleared");
  AST_CLR_B: assert property (port_b_output_latch_reset [*4] |-> dout_b == '0)
    else $error("port b latch not cleared");
  AST_GSR: assert property (!global_set_reset_n [*4] |-> dout_a == '0 && dout_b == '0)
    else $error("global clear missed a latch");
  cover property (en_a && we_a);
  cover property (en_b && we_b ##1 en_b && we_b);
  cover property (!global_set_reset_n ##1 global_set_reset_n);
endmodule : embedded_block_memory_checker
bind embedded_block_memory embedded_block_memory_checker #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B),
  .MODE_A(MODE_A), .MODE_B(MODE_B), .OUTREG_A(OUTREG_A), .OUTREG_B(OUTREG_B))
  u_chk (.clk, .rst_n, .global_set_reset_n, .port_a_output_latch_reset,
  .port_b_output_latch_reset, .en_a, .we_a, .addr_a, .din_a, .dout_a, .en_b, .we_b,
  .addr_b, .din_b, .dout_b);

//--- test/fabric_model.sv
`timescale 1ns/1ns
// user logic on both ports; idle lines flip so stale values never look fresh
module fabric_model (
  input  wire logic        clk,
  output logic       [1:0] en = '0,
  output logic       [1:0] we = '0,
  output logic [1:0][10:0] addr = '0,
  output logic [1:0][17:0] din = '0,
  output logic       [2:0] rst = '0
);
  task automatic op(input int p, input logic w, input logic [10:0] a, input logic [17:0] d);
    @(posedge clk);
    en[p]   <= 1'b1;
    we[p]   <= w;
    addr[p] <= a;
    din[p]  <= d;
  endtask : op
  task automatic idle(input int p);
    @(posedge clk);
    en[p]   <= 1'b0;
    addr[p] <= ~addr[p];
    din[p]  <= ~din[p];
  endtask : idle
  // bit 0 global clear (low), bits 1 and 2 the port clears, each driven alone
  task automatic rs(input int b, input logic v);
    @(posedge clk);
    rst[b] <= v;
  endtask : rs
endmodule : fabric_model

//--- test/test_embedded_block_memory.sv
`timescale 1ns/1ns
module test_embedded_block_memory;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic        [1:0] en, we;
  logic        [2:0] rs;
  logic [1:0][10:0] addr;
  logic [1:0][17:0] din;
  logic       [17:0] dout_a, dout_b;
  logic       [17:0] dout_na, dout_nb;
  int                error_cnt = 0, check_count = 0, cyc = 0;
  always #5 clk = ~clk;
  fabric_model fm (.clk, .en, .we, .addr, .din, .rst (rs));
  embedded_block_memory #(
    .MODE_A (block_memory_pkg::WRITE_THROUGH),
    .MODE_B (block_memory_pkg::READ_BEFORE)
  ) dut (
    .clk, .rst_n, .global_set_reset_n (rs[0]), .port_a_output_latch_reset (rs[1]),
    .port_b_output_latch_reset (rs[2]), .en_a (en[0]), .we_a (we[0]), .addr_a (addr[0]),
    .din_a (din[0]), .dout_a, .en_b (en[1]), .we_b (we[1]), .addr_b (addr[1]),
    .din_b (din[1]), .dout_b);
  // second block: normal mode, port a re-registered, asynchronous latch clears
  embedded_block_memory #(
    .OUTREG_A  (1'b1),
    .ASYNC_RST (1'b1)
  ) dut_n (
    .clk, .rst_n, .global_set_reset_n (rs[0]), .port_a_output_latch_reset (rs[1]),
    .port_b_output_latch_reset (rs[2]), .en_a (en[0]), .we_a (we[0]), .addr_a (addr[0]),
    .din_a (din[0]), .dout_a (dout_na), .en_b (en[1]), .we_b (we[1]), .addr_b (addr[1]),
    .din_b (din[1]), .dout_b (dout_nb));
  task automatic chk(input string n, input logic [17:0] e, input logic [17:0] s);
    check_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // back-to-back writes then a read of the first word
  task automatic t_write_through;
    fm.op(0, 1'b1, 11'h006, 18'h2a5a5);
    fm.op(0, 1'b1, 11'h007, 18'h15a5a);
    fm.op(0, 1'b0, 11'h006, 18'h3ffff);
    #1 chk("dout_a wt1", 18'h2a5a5, dout_a);
    chk("dout_na wr", 18'h00000, dout_na);
    fm.idle(0);
    #1 chk("dout_a wt2", 18'h15a5a, dout_a);
    @(posedge clk);
    #1 chk("dout_a read", 18'h2a5a5, dout_a);
    chk("dout_na lag", 18'h00000, dout_na);
    @(posedge clk);
    #1 chk("dout_na read", 18'h2a5a5, dout_na);
  endtask : t_write_through
  // second write shows the first word; port a then reads the new one
  task automatic t_read_before_write;
    fm.op(1, 1'b1, 11'h009, 18'h11111);
    fm.op(1, 1'b1, 11'h009, 18'h22222);
    fm.idle(1);
    @(posedge clk);
    #1 chk("dout_b old", 18'h11111, dout_b);
    chk("dout_nb wr", 18'h00000, dout_nb);
    fm.op(0, 1'b0, 11'h009, 18'h00000);
    fm.idle(0);
    @(posedge clk);
    #1 chk("dout_a new", 18'h22222, dout_a);
  endtask : t_read_before_write
  // each local clear alone, then the global one on both
  task automatic t_clears;
    fm.rs(1, 1'b1);
    #1 chk("dout_na async", 18'h00000, dout_na);
    chk("dout_a sync", 18'h22222, dout_a);
    repeat (4) @(posedge clk);
    #1 chk("dout_a clr", 18'h00000, dout_a);
    chk("dout_b kept", 18'h11111, dout_b);
    fm.rs(1, 1'b0);
    fm.rs(2, 1'b1);
    repeat (4) @(posedge clk);
    #1 chk("dout_b clr", 18'h00000, dout_b);
    fm.rs(2, 1'b0);
    fm.op(0, 1'b1, 11'h001, 18'h0aaaa);
    fm.op(1, 1'b1, 11'h009, 18'h05555);
    fm.idle(0);
    fm.idle(1);
    #1 chk("dout_b rbw", 18'h22222, dout_b);
    chk("dout_a wt", 18'h0aaaa, dout_a);
    fm.rs(0, 1'b0);
    repeat (4) @(posedge clk);
    #1 chk("dout_a gsr", 18'h00000, dout_a);
    chk("dout_b gsr", 18'h00000, dout_b);
    fm.rs(0, 1'b1);
  endtask : t_clears
  // whole run takes about 50 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 500) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    fm.rs(0, 1'b1);
    t_write_through();
    t_read_before_write();
    t_clears();
    end_sim();
  end
endmodule : test_embedded_block_memory
